// ### verilog/sirs_defines.vh
// Constants for the sensor interrupt status and register read port
// Operation
// - Status register at 0x8e; bit3 bio done, bit2 ambient, bit1 under, bit0 over.
// - Under-limit flag sets when a measurement passes the low threshold.
// - Over-limit flag sets when a measurement passes the high threshold.
// - Flags stick at one until host writes one; writing zero keeps them.
// - Interrupt pad pulled low while any status flag is one.
// - Timing register at 0x8f: delay 7:5, frequency 4:3, dead time 2:0.
// - Delay field sets detector evaluation start after emitter edge; resets zero.
// - Location 0x90 is reserved; contents are not to be relied on.
// - Without a measurement request the device idles with only the bus active.
// - In standby the emitter current sink is off regardless of current setting.
// - Read accepted after a stop or after a repeated start.
// - Register pointer advances by one after each byte read.
// - Device answers address byte 0x26 for writes and 0x27 for reads.
// - Low threshold is 16 bits, high byte 0x8a, low byte 0x8b.
`ifndef SIRS_DEFINES_VH
`define SIRS_DEFINES_VH
`define SIRS_ADDR_WR      8'h26
`define SIRS_ADDR_RD      8'h27
`define SIRS_REG_LOTH_HI  8'h8a
`define SIRS_REG_LOTH_LO  8'h8b
`define SIRS_REG_HITH_HI  8'h8c
`define SIRS_REG_HITH_LO  8'h8d
`define SIRS_REG_FLAGS    8'h8e
`define SIRS_REG_TIMING   8'h8f
`define SIRS_REG_AMB_IR   8'h90
`define SIRS_BIT_BIO      3
`define SIRS_BIT_AMB      2
`define SIRS_BIT_UNDER    1
`define SIRS_BIT_OVER     0
`define SIRS_TIM_DLY_MSB  7
`define SIRS_TIM_DLY_LSB  5
`define SIRS_TIM_FRQ_MSB  4
`define SIRS_TIM_FRQ_LSB  3
`define SIRS_TIM_DT_MSB   2
`define SIRS_TIM_DT_LSB   0
`define SIRS_RST_TIMING   8'h01
`define SIRS_RST_THRESH   16'h0000
`define SIRS_RST_HITH     16'hffff
`define SIRS_RSVD_VALUE   8'h00
`endif

// ### verilog/sirs_i2c_slave.v
// Two-wire target: byte engine producing register address, write data and read strobes
`timescale 1ns/100ps
module sirs_i2c_slave
(
   // Clock and reset
   input  wire       core_clk,
   input  wire       rst_b,
   // Pins, already synchronised
   input  wire       scl_s,
   input  wire       sda_s,
   output wire       sda_oe,
   // Register side
   output reg  [7:0] ptr_q,
   output reg        wr_stb_q,
   output reg  [7:0] wr_data_q,
   output reg        rd_stb_q,
   input  wire [7:0] rd_data
);
`include "sirs_defines.vh"
   localparam ST_IDLE = 6'h01;
   localparam ST_ADDR = 6'h02;
   localparam ST_REG  = 6'h04;
   localparam ST_WDAT = 6'h08;
   localparam ST_RDAT = 6'h10;
   localparam ST_RACK = 6'h20;

   reg [5:0] st_q;
   reg       scl_d1_q;
   reg       sda_d1_q;
   reg [7:0] sh_q;
   reg [3:0] cnt_q;
   reg       ack_q;
   reg       drv_q;

   wire scl_rise = scl_s & ~scl_d1_q;
   wire scl_fall = ~scl_s & scl_d1_q;
   wire start_c  = scl_s & sda_d1_q & ~sda_s;
   wire stop_c   = scl_s & ~sda_d1_q & sda_s;

   assign sda_oe = drv_q;

   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         st_q      <= ST_IDLE;
         scl_d1_q  <= 1'b1;
         sda_d1_q  <= 1'b1;
         sh_q      <= 8'h00;
         cnt_q     <= 4'h0;
         ack_q     <= 1'b0;
         drv_q     <= 1'b0;
         ptr_q     <= 8'h00;
         wr_stb_q  <= 1'b0;
         wr_data_q <= 8'h00;
         rd_stb_q  <= 1'b0;
      end
      else
      begin
         scl_d1_q <= scl_s;
         sda_d1_q <= sda_s;
         wr_stb_q <= 1'b0;
         rd_stb_q <= 1'b0;
         // Repeated start keeps the pointer, so a read may follow the address write directly
         if (start_c)
         begin
            st_q  <= ST_ADDR;
            cnt_q <= 4'h0;
            ack_q <= 1'b0;
            drv_q <= 1'b0;
         end
         else if (stop_c)
         begin
            st_q  <= ST_IDLE;
            drv_q <= 1'b0;
         end
         else if (scl_rise && !ack_q && st_q != ST_IDLE)
         begin
            sh_q  <= {sh_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
            if (st_q == ST_RACK)
            begin
               // Host nack ends the read, ack asks for the next byte
               if (sda_s)
                  st_q <= ST_IDLE;
               else
               begin
                  st_q  <= ST_RDAT;
                  cnt_q <= 4'h0;
               end
            end
         end
         else if (scl_fall)
         begin
            if (ack_q)
            begin
               ack_q <= 1'b0;
               drv_q <= 1'b0;
               cnt_q <= 4'h0;
               if (st_q == ST_RDAT)
                  drv_q <= ~rd_data[7];
            end
            else
            begin
               case (st_q)
                  ST_ADDR:
                     if (cnt_q == 4'h8)
                     begin
                        if (sh_q == `SIRS_ADDR_WR || sh_q == `SIRS_ADDR_RD)
                        begin
                           ack_q     <= 1'b1;
                           drv_q     <= 1'b1;
                           st_q      <= sh_q[0] ? ST_RDAT : ST_REG;
                        end
                        else
                           st_q <= ST_IDLE;
                     end
                  ST_REG:
                     if (cnt_q == 4'h8)
                     begin
                        ptr_q <= sh_q;
                        ack_q <= 1'b1;
                        drv_q <= 1'b1;
                        st_q  <= ST_WDAT;
                     end
                  ST_WDAT:
                     if (cnt_q == 4'h8)
                     begin
                        wr_data_q <= sh_q;
                        wr_stb_q  <= 1'b1;
                        ack_q     <= 1'b1;
                        drv_q     <= 1'b1;
                     end
                  ST_RDAT:
                     if (cnt_q == 4'h8)
                     begin
                        drv_q    <= 1'b0;
                        rd_stb_q <= 1'b1;
                        ptr_q    <= ptr_q + 8'h01;
                        st_q     <= ST_RACK;
                     end
                     else
                        drv_q <= ~rd_data[7 - cnt_q[2:0]];
                  default:
                     ;
               endcase
            end
         end
         // Step after the strobe, so the bank still decodes the old address
         if (wr_stb_q)
            ptr_q <= ptr_q + 8'h01;
      end
   end
endmodule // sirs_i2c_slave

// ### verilog/sirs_core.v
// Sensor interrupt status, modulator timing and register read port
`timescale 1ns/100ps
module sirs_core
(
   // Clock and reset
   input  wire        core_clk,
   input  wire        rst_b,
   // Two-wire bus pins
   input  wire        scl_in,
   input  wire        sda_in,
   output wire        sda_out,
   output wire        sda_oe,
   // Measurement events, same clock
   input  wire        bio_done_evt,
   input  wire        amb_done_evt,
   input  wire [15:0] meas_value,
   input  wire        meas_valid,
   input  wire        thresh_en,
   input  wire        meas_request,
   input  wire [7:0]  emitter_current,
   // Read-only result registers
   input  wire [7:0]  ext_rd_data,
   // Sensor control outputs
   output wire        int_n,
   output reg         infrared_emitter,
   output wire        standby,
   output wire [2:0]  delay_time,
   output wire [1:0]  bio_freq,
   output wire [2:0]  dead_time,
   output wire [7:0]  reg_ptr
);
`include "sirs_defines.vh"
   reg  [1:0]  scl_sync_q;
   reg  [1:0]  sda_sync_q;
   reg  [3:0]  flags_q;
   reg  [7:0]  timing_q;
   reg  [15:0] loth_q;
   reg  [15:0] hith_q;
   reg  [7:0]  rd_data;
   reg  [3:0]  set_v;
   wire [7:0]  ptr;
   wire        wr_stb;
   wire [7:0]  wr_data;

   assign sda_out = 1'b0;
   assign reg_ptr = ptr;

   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         scl_sync_q <= 2'b11;
         sda_sync_q <= 2'b11;
      end
      else
      begin
         scl_sync_q <= {scl_sync_q[0], scl_in};
         sda_sync_q <= {sda_sync_q[0], sda_in};
      end
   end

   sirs_i2c_slave u_slave
   (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .scl_s     (scl_sync_q[1]),
      .sda_s     (sda_sync_q[1]),
      .sda_oe    (sda_oe),
      .ptr_q     (ptr),
      .wr_stb_q  (wr_stb),
      .wr_data_q (wr_data),
      .rd_stb_q  (),
      .rd_data   (rd_data)
   );

   // Event sets, combined with clears below so that a set wins
   always @*
   begin
      set_v = 4'h0;
      set_v[`SIRS_BIT_BIO] = bio_done_evt;
      set_v[`SIRS_BIT_AMB] = amb_done_evt;
      set_v[`SIRS_BIT_UNDER] = meas_valid & thresh_en & (meas_value < loth_q);
      set_v[`SIRS_BIT_OVER]  = meas_valid & thresh_en & (meas_value > hith_q);
   end

   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         flags_q  <= 4'h0;
         timing_q <= `SIRS_RST_TIMING;
         loth_q   <= `SIRS_RST_THRESH;
         hith_q   <= `SIRS_RST_HITH;
      end
      else
      begin
         if (wr_stb && ptr == `SIRS_REG_FLAGS)
            flags_q <= (flags_q & ~wr_data[3:0]) | set_v;
         else
            flags_q <= flags_q | set_v;
         if (wr_stb && ptr == `SIRS_REG_TIMING)
            timing_q <= wr_data;
         if (wr_stb && ptr == `SIRS_REG_LOTH_HI)
            loth_q[15:8] <= wr_data;
         if (wr_stb && ptr == `SIRS_REG_LOTH_LO)
            loth_q[7:0] <= wr_data;
         if (wr_stb && ptr == `SIRS_REG_HITH_HI)
            hith_q[15:8] <= wr_data;
         if (wr_stb && ptr == `SIRS_REG_HITH_LO)
            hith_q[7:0] <= wr_data;
      end
   end

   always @*
   begin
      case (ptr)
         `SIRS_REG_FLAGS:   rd_data = {4'h0, flags_q};
         `SIRS_REG_TIMING:  rd_data = timing_q;
         `SIRS_REG_AMB_IR:  rd_data = `SIRS_RSVD_VALUE;
         `SIRS_REG_LOTH_HI: rd_data = loth_q[15:8];
         `SIRS_REG_LOTH_LO: rd_data = loth_q[7:0];
         `SIRS_REG_HITH_HI: rd_data = hith_q[15:8];
         `SIRS_REG_HITH_LO: rd_data = hith_q[7:0];
         default:           rd_data = ext_rd_data;
      endcase
   end

   assign int_n      = ~(|flags_q);
   assign standby    = ~meas_request;
   assign delay_time = timing_q[`SIRS_TIM_DLY_MSB:`SIRS_TIM_DLY_LSB];
   assign bio_freq   = timing_q[`SIRS_TIM_FRQ_MSB:`SIRS_TIM_FRQ_LSB];
   assign dead_time  = timing_q[`SIRS_TIM_DT_MSB:`SIRS_TIM_DT_LSB];

   // Emitter sink gated off in standby, so software can leave current set
   always @(posedge core_clk)
   begin
      if (!rst_b)
         infrared_emitter <= 1'b0;
      else
         infrared_emitter <= meas_request & (|emitter_current);
   end
endmodule // sirs_core

// ### verification/sirs_core_props.sv
// Checker for the sensor status and read port
`timescale 1ns/100ps
module sirs_core_props
(
   // Clock and reset
   input wire       core_clk,
   input wire       rst_b,
   // Observed ports
   input wire       scl_in,
   input wire       sda_oe,
   input wire       bio_done_evt,
   input wire       amb_done_evt,
   input wire       meas_request,
   input wire [7:0] emitter_current,
   input wire       int_n,
   input wire       infrared_emitter,
   input wire       standby,
   input wire [2:0] delay_time,
   input wire [1:0] bio_freq,
   input wire [2:0] dead_time,
   input wire [7:0] reg_ptr
);
   // Cycles since scl moved; state may only move with bus traffic
   reg       scl_p_q;
   reg [4:0] quiet_q;
   always @(posedge core_clk)
   begin
      scl_p_q <= scl_in;
      if (!rst_b || scl_in != scl_p_q)
         quiet_q <= 5'h00;
      else if (quiet_q != 5'h1f)
         quiet_q <= quiet_q + 5'h01;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   AST_STANDBY: assert property (standby == !meas_request)
      else $error("standby wrong");
   AST_EMIT: assert property (1'b1 |=> infrared_emitter == ($past(meas_request) && $past(emitter_current) != 8'h00))
      else $error("emitter wrong");
   AST_BIO_INT: assert property (bio_done_evt |=> !int_n)
      else $error("bio event no interrupt");
   AST_AMB_INT: assert property (amb_done_evt |=> !int_n)
      else $error("ambient event no interrupt");
   AST_INT_STICKY: assert property ($rose(int_n) |-> quiet_q < 5'h10)
      else $error("interrupt cleared without host");
   AST_SDA_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("sda moved with scl high");
   AST_TIM_QUIET: assert property ($changed({delay_time, bio_freq, dead_time}) |-> quiet_q < 5'h10)
      else $error("timing moved without host");
   AST_PTR_QUIET: assert property ($changed(reg_ptr) |-> quiet_q < 5'h10)
      else $error("pointer moved without host");
   cover property (bio_done_evt);
   cover property ($rose(int_n));
   cover property ($rose(sda_oe));
endmodule // sirs_core_props
bind sirs_core sirs_core_props u_props (.core_clk(core_clk), .rst_b(rst_b), .scl_in(scl_in), .sda_oe(sda_oe),
   .bio_done_evt(bio_done_evt), .amb_done_evt(amb_done_evt), .meas_request(meas_request),
   .emitter_current(emitter_current), .int_n(int_n), .infrared_emitter(infrared_emitter), .standby(standby),
   .delay_time(delay_time), .bio_freq(bio_freq), .dead_time(dead_time), .reg_ptr(reg_ptr));

// ### verification/sirs_host_model.sv
// Two-wire bus host model for the sensor port
`timescale 1ns/100ps
module sirs_host_model
(
   // Clock
   input  wire core_clk,
   // Bus
   input  wire sda_oe,
   output reg  scl,
   output wire sda
);
   // Pull-up wins unless a party pulls low
   reg pull;
   assign sda = !(pull | sda_oe);
   initial
   begin
      scl = 1'b1;
      pull = 1'b0;
   end
   // Ten cycles a phase, above the target's minimum
   task ph;
      repeat (10) @(negedge core_clk);
   endtask
   task start;
      pull = 1'b0;
      ph;
      scl = 1'b1;
      ph;
      pull = 1'b1;
      ph;
      scl = 1'b0;
   endtask
   task stop;
      pull = 1'b1;
      ph;
      scl = 1'b1;
      ph;
      pull = 1'b0;
      ph;
   endtask
   // Nine bits, MSB first; a one bit releases the line
   task xfer(input [8:0] d, output [8:0] q);
      for (int i = 8; i >= 0; i--)
      begin
         pull = !d[i];
         ph;
         scl = 1'b1;
         ph;
         q[i] = sda;
         scl = 1'b0;
      end
   endtask
endmodule // sirs_host_model

// ### verification/tb_sensor_irq_status_and_read_port.sv
// Self-checking bench for the sensor status and read port
`timescale 1ns/100ps
module tb_sensor_irq_status_and_read_port;
   reg         core_clk = 1'b0;
   reg         rst_b = 1'b0;
   reg         bio_done_evt = 1'b0;
   reg         amb_done_evt = 1'b0;
   reg  [15:0] meas_value = 16'h0000;
   reg         meas_valid = 1'b0;
   reg         thresh_en = 1'b0;
   reg         meas_request = 1'b0;
   reg  [7:0]  emitter_current = 8'h00;
   reg  [7:0]  ext_rd_data = 8'h00;
   wire        scl, sda, sda_oe, int_n, infrared_emitter, standby;
   wire [2:0]  delay_time, dead_time;
   wire [1:0]  bio_freq;
   wire [7:0]  reg_ptr, t8;
   integer     bad_count = 0;
   integer     n_compared = 0;
   integer     i;
   reg  [8:0]  q;
   reg  [15:0] v, lo, hi, m;
   reg  [7:0]  t;
   assign t8 = {delay_time, bio_freq, dead_time};
   always #50 core_clk = !core_clk;
   sirs_core dut (.core_clk(core_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
      .bio_done_evt(bio_done_evt), .amb_done_evt(amb_done_evt), .meas_value(meas_value), .meas_valid(meas_valid),
      .thresh_en(thresh_en), .meas_request(meas_request), .emitter_current(emitter_current),
      .ext_rd_data(ext_rd_data), .int_n(int_n), .infrared_emitter(infrared_emitter), .standby(standby),
      .delay_time(delay_time), .bio_freq(bio_freq), .dead_time(dead_time), .reg_ptr(reg_ptr));
   sirs_host_model host (.core_clk(core_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
   function [7:0] exp_flags(input [15:0] mv, input [15:0] l, input [15:0] h);
      exp_flags = {6'h00, mv < l, mv > h};
   endfunction
   task chk(input string nm, input [15:0] e, input [15:0] g);
      n_compared++;
      if (g !== e)
      begin
         bad_count++;
         $display("unexpected %0s exp %h got %h", nm, e, g);
      end
   endtask
   task bb(input [7:0] d, input nack);
      host.xfer({d, 1'b1}, q);
      chk("ack", {15'h0, nack}, {15'h0, q[0]});
   endtask
   task wr(input [7:0] a, input [15:0] d);
      host.start;
      bb(8'h26, 1'b0);
      bb(a, 1'b0);
      bb(d[15:8], 1'b0);
      bb(d[7:0], 1'b0);
      host.stop;
   endtask
   task rd(input [7:0] a, input rs, output [15:0] r);
      host.start;
      bb(8'h26, 1'b0);
      bb(a, 1'b0);
      if (!rs) host.stop;
      host.start;
      bb(8'h27, 1'b0);
      host.xfer(9'h1fe, q);
      r[15:8] = q[8:1];
      host.xfer(9'h1ff, q);
      r[7:0] = q[8:1];
      host.stop;
      chk("ptr", {8'h0, a + 8'h02}, {8'h0, reg_ptr});
   endtask
   task print_verdict;
      if (bad_count == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      i = $urandom(43);
      repeat (6) @(negedge core_clk);
      rst_b = 1'b1;
      repeat (2) @(negedge core_clk);
      chk("int_n", 16'h1, {15'h0, int_n});
      chk("timing", 16'h0001, {8'h0, t8});
      rd(8'h8f, 1'b0, v);
      chk("rd8f", 16'h0100, v);
      host.start;
      bb(8'h30, 1'b1);
      host.stop;
      emitter_current = 8'($urandom_range(255, 1));
      @(negedge core_clk);
      chk("emit", 16'h0, {15'h0, infrared_emitter});
      chk("stby", 16'h1, {15'h0, standby});
      meas_request = 1'b1;
      @(negedge core_clk);
      chk("emit", 16'h1, {15'h0, infrared_emitter});
      chk("stby", 16'h0, {15'h0, standby});
      meas_request = 1'b0;
      bio_done_evt = 1'b1;
      amb_done_evt = 1'b1;
      @(negedge core_clk);
      bio_done_evt = 1'b0;
      amb_done_evt = 1'b0;
      chk("int_n", 16'h0, {15'h0, int_n});
      wr(8'h8e, 16'h0401);
      rd(8'h8e, 1'b1, v);
      chk("flags", 16'h0801, v);
      thresh_en = 1'b1;
      for (i = 0; i < 8; i++)
      begin
         lo = 16'($urandom);
         hi = 16'($urandom);
         m = (i == 0) ? lo : (i == 1) ? hi : 16'($urandom);
         t = 8'($urandom);
         wr(8'h8e, {8'hff, t});
         chk("int_n", 16'h1, {15'h0, int_n});
         chk("timing", {8'h0, t}, {8'h0, t8});
         wr(8'h8a, lo);
         wr(8'h8c, hi);
         meas_value = m;
         meas_valid = 1'b1;
         @(negedge core_clk);
         meas_valid = 1'b0;
         ext_rd_data = 8'($urandom);
         rd(8'h89, 1'b1, v);
         chk("rd89", {ext_rd_data, lo[15:8]}, v);
         rd(8'h8e, i[0], v);
         chk("flags", {exp_flags(m, lo, hi), t}, v);
      end
      // Mid-run reset with a flag raised and timing left at a random value
      bio_done_evt = 1'b1;
      @(negedge core_clk);
      bio_done_evt = 1'b0;
      rst_b = 1'b0;
      repeat (6) @(negedge core_clk);
      rst_b = 1'b1;
      repeat (2) @(negedge core_clk);
      chk("int_n", 16'h1, {15'h0, int_n});
      chk("timing", 16'h0001, {8'h0, t8});
      rd(8'h8e, 1'b0, v);
      chk("flags", 16'h0001, v);
      print_verdict;
   end
   initial
   begin
      #6000000;
      bad_count++;
      print_verdict;
   end
endmodule // tb_sensor_irq_status_and_read_port
